// File: slk_cmd.sv
// slk_cmd: fieldbus slave interpreter for no-operation and identity read
// assumes: frame handed in through AXI4-Lite buffer, single clock aclk
// What this block does
// - a no-operation command (00h) does nothing and returns the present state.
// - identity read (03h) returns identification data of this slave.
// - the item returned is the one named by the selection code.
// - selector byte 4, offset byte 5, size bytes 6-7 are echoed, data in 8-31.
// - an unsupported selector sets the command alarm to 9h.
// - a bad offset or a size not matching the item sets the command alarm to 9h.
// - monitor bit 19 is 1 when speed is inside the zero-speed range.
// - monitor bits 24-31 show the eight general inputs in order.
// - the speed-match bit is 1 when speed is inside the speed-match range.
// - the speed-match bit is monitor bit 18.
`timescale 1ns/1ns
module slk_cmd (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic signed [15:0]  speed,
   input  wire logic [7:0]          general_input_bits,
   output logic                     command_ready_flag
);
   import slk_pkg::*;

   typedef enum logic [1:0] {SLK_IDLE, SLK_BUSY} slk_state_e;

   // pin-side inputs pass two flops first
   logic [7:0]  in_s1_q, in_s2_q;
   logic [15:0] spd_s1_q, spd_s2_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_s1_q  <= 8'h00;
         in_s2_q  <= 8'h00;
         spd_s1_q <= 16'h0000;
         spd_s2_q <= 16'h0000;
      end else begin
         in_s1_q  <= general_input_bits;
         in_s2_q  <= in_s1_q;
         spd_s1_q <= speed;
         spd_s2_q <= spd_s1_q;
      end
   end

   // register state
   logic [7:0]  cbuf_q [FRAME_BYTES];
   logic [7:0]  rbuf_q [FRAME_BYTES];
   logic [7:0]  rbuf_d [FRAME_BYTES];
   logic [7:0]  cbuf_d [FRAME_BYTES];
   logic [15:0] zs_lim_q, zs_lim_d, vm_tgt_q, vm_tgt_d, vm_rng_q, vm_rng_d;
   logic [31:0] ver_q, ver_d, mon_q, mon_d, rdata_q, rdata_d;
   logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d;
   logic [3:0]  ws_q, ws_d;
   logic        rdy_q, rdy_d;
   logic [3:0]  alm_q, alm_d, cnt_q, cnt_d;
   slk_state_e  st_q, st_d;
   logic        id_ok;
   logic [31:0] id_item;

   slk_idrom slk_idrom_i (
      .sel          (cbuf_q[B_SEL]),
      .dev_version  (ver_q),
      .file_version (ver_q[31:16]),
      .valid        (id_ok),
      .item         (id_item)
   );

   // monitor word: absolute speed against zero-speed range, speed-to-target distance against match range
   logic [15:0] spd_abs, vm_diff;
   always_comb begin
      spd_abs = spd_s2_q[15] ? 16'(-spd_s2_q) : spd_s2_q;
      // speed and target are both signed, so order them as signed values
      vm_diff = ($signed(spd_s2_q) >= $signed(vm_tgt_q)) ? 16'(spd_s2_q - vm_tgt_q)
                                                         : 16'(vm_tgt_q - spd_s2_q);
      mon_d = 32'h0000_0000;
      mon_d[MON_ZERO_SPEED]  = (spd_abs <= zs_lim_q);
      mon_d[MON_SPEED_MATCH] = (vm_diff <= vm_rng_q);
      mon_d[MON_INPUT_LSB +: 8] = in_s2_q;
   end

   // bus, command sequencer and response builder
   logic        wr_go, go_cmd;
   logic [15:0] req_size;
   logic [7:0]  req_ofs;
   always_comb begin
      aw_d = aw_q;  w_d = w_q;  bv_d = bv_q;  rv_d = rv_q;
      awa_d = awa_q;  wd_d = wd_q;  ws_d = ws_q;
      bresp_d = bresp_q;  rresp_d = rresp_q;  rdata_d = rdata_q;
      zs_lim_d = zs_lim_q;  vm_tgt_d = vm_tgt_q;  vm_rng_d = vm_rng_q;
      ver_d = ver_q;  cbuf_d = cbuf_q;  rbuf_d = rbuf_q;
      rdy_d = rdy_q;  alm_d = alm_q;  cnt_d = cnt_q;  st_d = st_q;
      go_cmd = 1'b0;
      req_ofs  = cbuf_q[B_OFS];
      req_size = {cbuf_q[B_SIZE1], cbuf_q[B_SIZE0]};
      // address and data taken in either order
      if (s_axi_awvalid && !aw_q) begin
         aw_d = 1'b1;  awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
         w_d = 1'b1;  wd_d = s_axi_wdata;  ws_d = s_axi_wstrb;
      end
      wr_go = aw_q && w_q && !bv_q;
      if (wr_go) begin
         aw_d = 1'b0;  w_d = 1'b0;  bv_d = 1'b1;  bresp_d = RESP_OKAY;
         if (awa_q >= A_CMDBUF && awa_q < A_RSPBUF) begin
            for (int i = 0; i < 4; i++)
               if (ws_q[i])
                  cbuf_d[{awa_q[4:2], 2'(i)}] = wd_q[8*i +: 8];
         end else case (awa_q)
            A_CTRL:      go_cmd = wd_q[0] && (st_q == SLK_IDLE);
            A_ZS_LIMIT:  zs_lim_d = wd_q[15:0];
            A_VM_TARGET: vm_tgt_d = wd_q[15:0];
            A_VM_RANGE:  vm_rng_d = wd_q[15:0];
            A_ID_VER:    ver_d = wd_q;
            default:     bresp_d = RESP_SLVERR;
         endcase
      end
      if (bv_q && s_axi_bready)
         bv_d = 1'b0;
      // reads
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;  rresp_d = RESP_OKAY;  rdata_d = 32'h0000_0000;
         if (s_axi_araddr >= A_CMDBUF && s_axi_araddr < A_RSPBUF)
            for (int i = 0; i < 4; i++)
               rdata_d[8*i +: 8] = cbuf_q[{s_axi_araddr[4:2], 2'(i)}];
         else if (s_axi_araddr >= A_RSPBUF && s_axi_araddr < A_ZS_LIMIT)
            for (int i = 0; i < 4; i++)
               rdata_d[8*i +: 8] = rbuf_q[{s_axi_araddr[4:2], 2'(i)}];
         else case (s_axi_araddr)
            A_CTRL:      rdata_d = 32'h0000_0000;
            A_STATUS:    rdata_d = {24'h00_0000, alm_q, 3'b000, rdy_q};
            A_MONITOR:   rdata_d = mon_q;
            A_ZS_LIMIT:  rdata_d = {16'h0000, zs_lim_q};
            A_VM_TARGET: rdata_d = {16'h0000, vm_tgt_q};
            A_VM_RANGE:  rdata_d = {16'h0000, vm_rng_q};
            A_ID_VER:    rdata_d = ver_q;
            default:     rresp_d = RESP_SLVERR;
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      // command sequencer: ready low while busy
      case (st_q)
         SLK_IDLE: begin
            if (go_cmd) begin
               rdy_d = 1'b0;
               cnt_d = BUSY_CYCLES;
               st_d  = SLK_BUSY;
            end
         end
         SLK_BUSY: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else begin
               for (int i = 0; i < FRAME_BYTES; i++)
                  rbuf_d[i] = 8'h00;
               rbuf_d[B_CODE] = cbuf_q[B_CODE];
               rbuf_d[B_WATCHDOG] = cbuf_q[B_WATCHDOG];
               alm_d = ALARM_NONE;
               if (cbuf_q[B_CODE] == CMD_IDRD) begin
                  rbuf_d[B_SEL]   = cbuf_q[B_SEL];
                  rbuf_d[B_OFS]   = req_ofs;
                  rbuf_d[B_SIZE0] = cbuf_q[B_SIZE0];
                  rbuf_d[B_SIZE1] = cbuf_q[B_SIZE1];
                  if (!id_ok)
                     alm_d = ALARM_BAD_PARAM;
                  else if (req_ofs >= 8'(ID_ITEM_SIZE) ||
                           req_size != ID_ITEM_SIZE - 16'(req_ofs))
                     alm_d = ALARM_BAD_PARAM;
                  else
                     for (int i = 0; i < 4; i++)
                        if (i >= int'(req_ofs))
                           rbuf_d[B_DATA + i - int'(req_ofs)] = id_item[8*i +: 8];
               end
               rbuf_d[B_STAT0][ST_RDY_BIT] = 1'b1;
               rbuf_d[B_STAT1][ST_ALM_LSB - 8 +: 4] = alm_d;
               rdy_d = 1'b1;
               st_d  = SLK_IDLE;
            end
         end
         default: st_d = SLK_IDLE;
      endcase
   end

   // register all state except the two-flop input stages
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;  w_q <= 1'b0;  bv_q <= 1'b0;  rv_q <= 1'b0;
         awa_q <= 8'h00;  wd_q <= 32'h0000_0000;  ws_q <= 4'h0;
         bresp_q <= RESP_OKAY;  rresp_q <= RESP_OKAY;  rdata_q <= 32'h0000_0000;
         zs_lim_q <= 16'h0000;  vm_tgt_q <= 16'h0000;  vm_rng_q <= 16'h0000;
         ver_q <= 32'h0000_0000;  mon_q <= 32'h0000_0000;
         rdy_q <= 1'b1;  alm_q <= ALARM_NONE;  cnt_q <= 4'h0;  st_q <= SLK_IDLE;
         for (int i = 0; i < FRAME_BYTES; i++) begin
            cbuf_q[i] <= 8'h00;
            rbuf_q[i] <= 8'h00;
         end
      end else begin
         aw_q <= aw_d;  w_q <= w_d;  bv_q <= bv_d;  rv_q <= rv_d;
         awa_q <= awa_d;  wd_q <= wd_d;  ws_q <= ws_d;
         bresp_q <= bresp_d;  rresp_q <= rresp_d;  rdata_q <= rdata_d;
         zs_lim_q <= zs_lim_d;  vm_tgt_q <= vm_tgt_d;  vm_rng_q <= vm_rng_d;
         ver_q <= ver_d;  mon_q <= mon_d;
         rdy_q <= rdy_d;  alm_q <= alm_d;  cnt_q <= cnt_d;  st_q <= st_d;
         cbuf_q <= cbuf_d;
         rbuf_q <= rbuf_d;
      end
   end

   // outputs straight from flops
   assign s_axi_awready      = !aw_q;
   assign s_axi_wready       = !w_q;
   assign s_axi_bvalid       = bv_q;
   assign s_axi_bresp        = bresp_q;
   assign s_axi_arready      = !rv_q;
   assign s_axi_rvalid       = rv_q;
   assign s_axi_rdata        = rdata_q;
   assign s_axi_rresp        = rresp_q;
   assign command_ready_flag = rdy_q;
endmodule

// File: slk_pkg.sv
// slk_pkg: constants for the fieldbus common-command interpreter
// assumes: 32-byte frames, AXI4-Lite register access, 100 MHz aclk
package slk_pkg;
   localparam int          FRAME_BYTES      = 32;
   localparam logic [7:0]  CMD_NO_OPERATION = 8'h00;  // no_operation_cmd
   localparam logic [7:0]  CMD_IDRD         = 8'h03;  // identity_read_cmd
   localparam logic [3:0]  ALARM_BAD_PARAM  = 4'h9;
   localparam logic [3:0]  ALARM_NONE       = 4'h0;
   // frame byte positions
   localparam int          B_CODE           = 0;
   localparam int          B_WATCHDOG       = 1;
   localparam int          B_STAT0          = 2;
   localparam int          B_STAT1          = 3;
   localparam int          B_SEL            = 4;
   localparam int          B_OFS            = 5;
   localparam int          B_SIZE0          = 6;
   localparam int          B_SIZE1          = 7;
   localparam int          B_DATA           = 8;
   localparam int          ID_ROOM          = 24;
   // status word fields (bytes 2-3)
   localparam int          ST_ALM_LSB       = 8;
   localparam int          ST_RDY_BIT       = 3;
   // identity items: selector range and fixed 4-byte size
   localparam logic [7:0]  SEL_FIRST        = 8'h01;
   localparam logic [7:0]  SEL_LAST         = 8'h04;
   localparam logic [15:0] ID_ITEM_SIZE     = 16'h0004;
   // monitor word bit positions
   localparam int          MON_SPEED_MATCH  = 18;
   localparam int          MON_ZERO_SPEED   = 19;
   localparam int          MON_INPUT_LSB    = 24;
   // busy counter load of an asynchronous command; ready stays low for this value plus one, 5 aclk cycles
   localparam logic [3:0]  BUSY_CYCLES      = 4'h4;
   // register byte addresses
   localparam logic [7:0]  A_CTRL           = 8'h00;  // bit0 go (write 1 = pulse)
   localparam logic [7:0]  A_STATUS         = 8'h04;  // bit0 ready, [7:4] alarm
   localparam logic [7:0]  A_MONITOR        = 8'h08;
   localparam logic [7:0]  A_CMDBUF         = 8'h20;  // 8 words of command frame
   localparam logic [7:0]  A_RSPBUF         = 8'h40;  // 8 words of response frame
   localparam logic [7:0]  A_ZS_LIMIT       = 8'h60;  // zero speed range
   localparam logic [7:0]  A_VM_TARGET      = 8'h64;  // speed match target
   localparam logic [7:0]  A_VM_RANGE       = 8'h68;  // speed match range
   localparam logic [7:0]  A_ID_VER         = 8'h6C;  // device and file versions
   localparam logic [1:0]  RESP_OKAY        = 2'b00;
   localparam logic [1:0]  RESP_SLVERR      = 2'b10;
endpackage

// File: slk_idrom.sv
// slk_idrom: identity item lookup by selector code
// assumes: ids supplied as parameters; values are arbitrary stand-ins
`timescale 1ns/1ns
module slk_idrom #(
   parameter logic [31:0] VENDOR_CODE = 32'h0000_1234,  // arbitrary value
   parameter logic [31:0] DEVICE_CODE = 32'h0000_5678   // arbitrary value
) (
   input  wire logic [7:0]  sel,
   input  wire logic [31:0] dev_version,
   input  wire logic [15:0] file_version,
   output logic             valid,
   output logic [31:0]      item
);
   import slk_pkg::*;
   // pick one 4-byte item; unsupported selectors are flagged invalid
   always_comb begin
      valid = 1'b1;
      case (sel)
         8'h01:   item = VENDOR_CODE;
         8'h02:   item = DEVICE_CODE;
         8'h03:   item = dev_version;
         8'h04:   item = {16'h0000, file_version};
         default: begin
            item  = 32'h0000_0000;
            valid = 1'b0;
         end
      endcase
   end
endmodule

// File: slk_cmd_checker.sv
// slk_cmd_checker: bus and status checks on the slk_cmd ports
// assumes: bound to every slk_cmd instance, single clock aclk
`timescale 1ns/1ns
module slk_cmd_checker
   import slk_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        command_ready_flag
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic rd_go;
   // a read address taken at this edge
   assign rd_go = s_axi_arvalid && s_axi_arready;
   a_busy_span: assert property ($fell(command_ready_flag) |->
      (!command_ready_flag)[*3] ##[1:4] command_ready_flag) else $error("bad busy span");
   a_status_ready: assert property (rd_go && s_axi_araddr == A_STATUS |=>
      s_axi_rdata[0] == $past(command_ready_flag)) else $error("bad status ready");
   a_rsp_reserved: assert property (rd_go && s_axi_araddr == A_RSPBUF |=>
      s_axi_rdata[31:28] == 4'h0 && s_axi_rdata[23:20] == 4'h0 && s_axi_rdata[18:16] == 3'h0)
      else $error("reserved status bits set");
   a_ctrl_zero: assert property (rd_go && s_axi_araddr == A_CTRL |=> s_axi_rdata == 32'h0)
      else $error("control reads nonzero");
   a_unmapped_read: assert property (rd_go && s_axi_araddr inside {[8'h0C:8'h1C]} |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read taken");
   a_read_answer: assert property (rd_go |=> s_axi_rvalid) else $error("read answer late");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
   a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   c_cmd_done: cover property ($rose(command_ready_flag));
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_rsp_read: cover property (rd_go && s_axi_araddr == A_RSPBUF);
endmodule
bind slk_cmd slk_cmd_checker slk_cmd_checker_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .command_ready_flag(command_ready_flag)
);

// File: slk_mst.sv
// slk_mst: fieldbus master model sending command frames over the register bus
// assumes: instanced in slk_cmd_tb, which owns the hang task
`timescale 1ns/1ns
module slk_mst
   import slk_pkg::*;
(
   input  wire logic        aclk,
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   // idle bus at time zero
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hF;
   end
   // one write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (bvalid) break;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      if (n == 50) slk_cmd_tb.hang();
      r = bresp;
      {awvalid, wvalid, bready} <= 3'h0;
   endtask
   // one read, answer taken at the edge where rvalid is seen
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (rvalid) break;
         if (arready) arvalid <= 1'b0;
      end
      if (n == 50) slk_cmd_tb.hang();
      d = rdata;
      r = rresp;
      {arvalid, rready} <= 2'h0;
   endtask
   // send a frame head, start it, wait for ready, then fetch the response head
   task automatic run_cmd(input logic [31:0] w0, w1, output logic [31:0] rsp [3]);
      logic [31:0] st;
      logic [1:0]  r;
      int          n;
      wr(A_CMDBUF, w0, r);
      wr(A_CMDBUF + 8'h04, w1, r);
      wr(A_CTRL, 32'h1, r);
      for (n = 0; n < 20; n++) begin
         rd(A_STATUS, st, r);
         if (st[0] === 1'b1) break;
      end
      if (n == 20) slk_cmd_tb.hang();
      for (n = 0; n < 3; n++) rd(A_RSPBUF + 8'(4 * n), rsp[n], r);
   endtask
endmodule

// File: slk_cmd_tb.sv
// slk_cmd_tb: self-checking bench for the common-command interpreter
// assumes: slk_mst plays the fieldbus master, the bench drives the field pins
`timescale 1ns/1ns
module slk_cmd_tb;
   import slk_pkg::*;
   logic               aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic               arvalid, arready, rvalid, rready, cmd_rdy;
   logic [7:0]         awaddr, araddr, gib;
   logic [31:0]        wdata, rdata, d, e;
   logic [3:0]         wstrb;
   logic [1:0]         bresp, rresp, r;
   logic signed [15:0] speed;
   logic [31:0]        rsp [3];
   int                 num_errors = 0;
   int                 checked = 0;
   logic signed [15:0] spd [6] = '{16'sh0000, 16'shFFF6, 16'sh000B, 16'sh005F, 16'sh006A,
                                   16'sh0069};
   logic [31:0]        idp [7] = '{32'h0003_0103, 32'h0004_0004, 32'h0004_0001,
                                   32'h0004_0005, 32'h0004_0000, 32'h0000_0402, 32'h0004_0102};
   logic [3:0]         ida [7] = '{4'h0, 4'h0, 4'h0, 4'h9, 4'h9, 4'h9, 4'h9};
   logic [31:0]        idd [2] = '{32'h00BE_EFC0, 32'h0000_BEEF};
   slk_cmd slk_cmd_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .speed(speed), .general_input_bits(gib), .command_ready_flag(cmd_rdy)
   );
   slk_mst slk_mst_i (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );
   // compare one word and count it
   task automatic chk(input logic [31:0] got, exp, input string m);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // a bounded bus wait ran out
   task automatic hang();
      num_errors++;
      $display("mismatch at %0t: bus wait ran out", $time);
      print_verdict();
   endtask
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // main sequence
   initial begin
      int s;
      {aresetn, gib, speed} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      slk_mst_i.rd(A_STATUS, d, r);
      chk(d, 32'h1, "status after reset");
      slk_mst_i.rd(A_CTRL, d, r);
      chk(d, 32'h0, "control read");
      $display("test reset done");
      // monitor word over a table of speeds, one input walking per step
      slk_mst_i.wr(A_ZS_LIMIT, 32'h0000_000A, r);
      slk_mst_i.wr(A_VM_TARGET, 32'h0000_0064, r);
      slk_mst_i.wr(A_VM_RANGE, 32'h0000_0005, r);
      foreach (spd[i]) begin
         s = spd[i];
         speed <= spd[i];
         gib <= 8'h80 >> i;
         repeat (8) @(posedge aclk);
         slk_mst_i.rd(A_MONITOR, d, r);
         e = {8'h80 >> i, 4'h0, s >= -10 && s <= 10, s >= 95 && s <= 105, 18'h0};
         chk(d, e, "monitor");
      end
      $display("test monitor done");
      // identity reads: good items, bad selectors, bad offset and size
      slk_mst_i.wr(A_ID_VER, 32'hBEEF_C0DE, r);
      foreach (idp[i]) begin
         slk_mst_i.run_cmd({16'h0, 8'(8'h10 + i), CMD_IDRD}, idp[i], rsp);
         e = {4'h0, ida[i], 8'h08, 8'(8'h10 + i), CMD_IDRD};
         chk(rsp[0], e, "id head");
         chk(rsp[1], idp[i], "id echo");
         if (i < 2) chk(rsp[2], idd[i], "id data");
         slk_mst_i.rd(A_STATUS, d, r);
         chk(d, {24'h0, ida[i], 4'h1}, "alarm field");
      end
      $display("test identity done");
      // no-operation after an identity read clears the parameter and data fields
      slk_mst_i.run_cmd(32'h0000_5A00, 32'h0, rsp);
      chk(rsp[0], 32'h0008_5A00, "no-operation head");
      chk(rsp[1], 32'h0, "no-operation params");
      chk(rsp[2], 32'h0, "no-operation data");
      $display("test no-operation done");
      // refused accesses
      foreach (idd[i]) begin
         slk_mst_i.wr(i == 0 ? 8'h10 : A_RSPBUF, 32'h1, r);
         chk({30'h0, r}, {30'h0, RESP_SLVERR}, "refused write");
      end
      slk_mst_i.rd(8'h1C, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
      $display("test refusal done");
      print_verdict();
   end
endmodule
